// File: dma_channel_control.sv
// Two-channel DMA register file, AXI4-Lite slave and transfer sequencer
// Operation
// - Destination step 00 fixed; 11 reserved
// - Destination step 01 adds unit size
// - Destination step 10 subtracts unit size
// - Source fixed, but sixteen-byte still advances
// - Source step 01 adds unit size
// - Source step 10 subtracts unit size
// - Size field: byte, word, long, sixteen
// - Request mode: external zero, auto one
// - Ack phase: read cycle or write
// - Ack polarity: low zero, high one
// - Request sense level/edge, low/high polarity
// - Cycle-steal releases bus; burst keeps it
// - Dual address or single address mode
// - Interrupt needs interrupt enable set
// - End flag set only at count zero
// - End flag cleared by read one, write zero
// - Channel enable permits transfers
// - Count decrements; upper byte reads zero
// - Destination address register feeds write address
// - Global enable gates both channels
// - Request source: pin, receive, transmit; 11 none
`include "dma_chan_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  transfer_request_pin,
  input  wire logic        rx_full_req,
  input  wire logic        tx_empty_req,
  output logic [1:0]       transfer_acknowledge,
  output logic [1:0]       end_irq,
  output logic [31:0]      bus_addr,
  output logic             bus_read,
  output logic             bus_write,
  output logic             bus_owned
);
  dma_chan_pkg::ctl_state_t q;
  dma_chan_pkg::ctl_state_t d;
  logic [1:0]              pin_req;
  logic [1:0]              take;
  logic [1:0][31:0]        src_nx;
  logic [1:0][31:0]        dst_nx;
  logic [1:0]              req;
  logic [1:0]              run;
  logic                    done;

  // Address decode, shared by the read and write paths
  function automatic dma_chan_pkg::reg_sel_t decode(input logic [31:0] a);
    unique case (a)
      `OFS_SRC0: decode = dma_chan_pkg::R_SRC0;
      `OFS_DST0: decode = dma_chan_pkg::R_DST0;
      `OFS_CNT0: decode = dma_chan_pkg::R_CNT0;
      `OFS_CTL0: decode = dma_chan_pkg::R_CTL0;
      `OFS_SRC1: decode = dma_chan_pkg::R_SRC1;
      `OFS_DST1: decode = dma_chan_pkg::R_DST1;
      `OFS_CNT1: decode = dma_chan_pkg::R_CNT1;
      `OFS_CTL1: decode = dma_chan_pkg::R_CTL1;
      `OFS_RSEL: decode = dma_chan_pkg::R_RSEL;
      `OFS_OPER: decode = dma_chan_pkg::R_OPER;
      default:   decode = dma_chan_pkg::R_NONE;
    endcase
  endfunction : decode

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        merge[i*8 +: 8] = nw[i*8 +: 8];
  endfunction : merge

  //////////////////////////////////////////////////////////////////////////////
  // Per-channel request sensing and address stepping
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    dma_req_sense u_sense (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .pin       (transfer_request_pin[c]),
      .edge_mode (q.ctrl[c][`CTL_REQ_EDG]),
      .pol_high  (q.ctrl[c][`CTL_REQ_POL]),
      .take      (take[c]),
      .req       (pin_req[c])
    );
    dma_addr_step u_src (
      .addr_in  (q.src[c]),
      .step     (q.ctrl[c][`CTL_SSTEP +: 2]),
      .size     (q.ctrl[c][`CTL_SIZE +: 2]),
      .src_side (1'b1),
      .addr_out (src_nx[c])
    );
    dma_addr_step u_dst (
      .addr_in  (q.dst[c]),
      .step     (q.ctrl[c][`CTL_DSTEP +: 2]),
      .size     (q.ctrl[c][`CTL_SIZE +: 2]),
      .src_side (1'b0),
      .addr_out (dst_nx[c])
    );
    // Request source choice; the prohibited code gives no request
    always_comb
    begin
      unique case (q.rsel[c])
        2'h0: req[c] = pin_req[c];
        2'h1: req[c] = rx_full_req;
        2'h2: req[c] = tx_empty_req;
        2'h3: req[c] = 1'b0;
      endcase
      if (q.ctrl[c][`CTL_AUTO])
        req[c] = 1'b1;
    end
    // Channel may run only while channel and global enables hold and it has not ended
    assign run[c] = q.ctrl[c][`CTL_CH_EN] & q.glob_en & ~q.ctrl[c][`CTL_END];
    assign end_irq[c] = q.ctrl[c][`CTL_END] & q.ctrl[c][`CTL_IRQ_EN];
    assign transfer_acknowledge[c] = q.ack_on[c] ~^ q.ctrl[c][`CTL_ACK_POL];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave first, sequencer after so its updates win
  always_comb
  begin
    logic [31:0]             wd;
    logic [15:0]             cw;
    logic                    c;
    logic                    ph;
    logic [1:0]              last;
    dma_chan_pkg::reg_sel_t  ws;
    d    = q;
    take = 2'h0;
    wd   = 32'h0;
    cw   = 16'h0;
    c    = q.ch;
    done = 1'b0;
    ph   = q.ctrl[q.ch][`CTL_ACK_PH];
    last = (q.ctrl[q.ch][`CTL_SIZE +: 2] == 2'h3) ? `LAST_BEAT16 : 2'h0;
    ws   = decode(q.aw_addr);

    // Capture write address and data in either order
    if (s_axi_awvalid && !q.aw_have)
    begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_have)
    begin
      d.w_have = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;

    // Perform a held write once both halves are in and no answer is pending
    if (q.aw_have && q.w_have && !q.bvalid)
    begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = (ws == dma_chan_pkg::R_NONE) ? `RESP_SLVERR : `RESP_OK;
      unique case (ws)
        dma_chan_pkg::R_SRC0: d.src[0] = merge(q.src[0], q.w_data, q.w_strb);
        dma_chan_pkg::R_SRC1: d.src[1] = merge(q.src[1], q.w_data, q.w_strb);
        dma_chan_pkg::R_DST0: d.dst[0] = merge(q.dst[0], q.w_data, q.w_strb);
        dma_chan_pkg::R_DST1: d.dst[1] = merge(q.dst[1], q.w_data, q.w_strb);
        dma_chan_pkg::R_CNT0, dma_chan_pkg::R_CNT1:
        begin
          wd = merge({8'h00, q.count[ws == dma_chan_pkg::R_CNT1]}, q.w_data, q.w_strb);
          d.count[ws == dma_chan_pkg::R_CNT1] = wd[23:0];
        end
        dma_chan_pkg::R_CTL0, dma_chan_pkg::R_CTL1:
        begin
          c  = (ws == dma_chan_pkg::R_CTL1);
          wd = merge({16'h0000, q.ctrl[c]}, q.w_data, q.w_strb);
          cw = wd[15:0];
          // End flag: writing one is ignored; zero clears only after one was read
          cw[`CTL_END] = q.ctrl[c][`CTL_END];
          if (q.w_strb[0] && !q.w_data[`CTL_END] && q.end_seen[c])
            cw[`CTL_END] = 1'b0;
          d.ctrl[c]     = cw;
          d.end_seen[c] = 1'b0;
          c             = q.ch;
        end
        dma_chan_pkg::R_RSEL:
        begin
          wd     = merge({28'h0, q.rsel}, q.w_data, q.w_strb);
          d.rsel = wd[3:0];
        end
        dma_chan_pkg::R_OPER:
        begin
          wd        = merge({31'h0, q.glob_en}, q.w_data, q.w_strb);
          d.glob_en = wd[`OPER_GEN];
        end
        dma_chan_pkg::R_NONE: d.bresp = `RESP_SLVERR;
      endcase
    end

    // Read path: answer in the same edge that takes the address
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (s_axi_arvalid && !q.rvalid)
    begin
      d.rvalid = 1'b1;
      d.rresp  = `RESP_OK;
      unique case (decode(s_axi_araddr))
        dma_chan_pkg::R_SRC0: d.rdata = q.src[0];
        dma_chan_pkg::R_SRC1: d.rdata = q.src[1];
        dma_chan_pkg::R_DST0: d.rdata = q.dst[0];
        dma_chan_pkg::R_DST1: d.rdata = q.dst[1];
        dma_chan_pkg::R_CNT0: d.rdata = {8'h00, q.count[0]};
        dma_chan_pkg::R_CNT1: d.rdata = {8'h00, q.count[1]};
        dma_chan_pkg::R_CTL0:
        begin
          d.rdata = {16'h0000, q.ctrl[0]};
          if (q.ctrl[0][`CTL_END])
            d.end_seen[0] = 1'b1;
        end
        dma_chan_pkg::R_CTL1:
        begin
          d.rdata = {16'h0000, q.ctrl[1]};
          if (q.ctrl[1][`CTL_END])
            d.end_seen[1] = 1'b1;
        end
        dma_chan_pkg::R_RSEL: d.rdata = {28'h0, q.rsel};
        dma_chan_pkg::R_OPER: d.rdata = {31'h0, q.glob_en};
        dma_chan_pkg::R_NONE:
        begin
          d.rdata = 32'h0;
          d.rresp = `RESP_SLVERR;
        end
      endcase
    end

    // Sequencer; channel 0 has fixed priority when both are ready
    unique case (q.st)
      dma_chan_pkg::ST_IDLE, dma_chan_pkg::ST_GAP:
      begin
        d.beat = 2'h0;
        d.st   = dma_chan_pkg::ST_IDLE;
        for (int k = 1; k >= 0; k--)
          if (run[k] && req[k] && q.count[k] != 24'h0)
          begin
            d.ch = k[0];
            d.st = q.ctrl[k][`CTL_SINGLE] ? dma_chan_pkg::ST_SINGLE : dma_chan_pkg::ST_READ;
          end
      end
      dma_chan_pkg::ST_READ:
        d.st = run[q.ch] ? dma_chan_pkg::ST_WRITE : dma_chan_pkg::ST_IDLE;
      dma_chan_pkg::ST_WRITE, dma_chan_pkg::ST_SINGLE:
      begin
        if (!run[q.ch])
          d.st = dma_chan_pkg::ST_IDLE;
        else if (q.beat != last)
        begin
          d.beat = q.beat + 2'h1;
          d.st   = q.ctrl[q.ch][`CTL_SINGLE] ? dma_chan_pkg::ST_SINGLE : dma_chan_pkg::ST_READ;
        end
        else
          done = 1'b1;
      end
    endcase

    // Unit finished: step both addresses, count down, maybe end
    if (done)
    begin
      take[q.ch]     = 1'b1;
      d.src[q.ch]    = src_nx[q.ch];
      d.dst[q.ch]    = dst_nx[q.ch];
      d.count[q.ch]  = q.count[q.ch] - 24'h1;
      d.beat         = 2'h0;
      if (q.count[q.ch] == 24'h1)
      begin
        d.ctrl[q.ch][`CTL_END] = 1'b1;
        d.st = dma_chan_pkg::ST_IDLE;
      end
      else if (q.ctrl[q.ch][`CTL_BURST] && req[q.ch])
        d.st = q.ctrl[q.ch][`CTL_SINGLE] ? dma_chan_pkg::ST_SINGLE : dma_chan_pkg::ST_READ;
      else
        d.st = dma_chan_pkg::ST_GAP;
    end

    // Bus outputs follow the next state so they come from flops
    ph         = d.ctrl[d.ch][`CTL_ACK_PH];
    d.bus_rd   = (d.st == dma_chan_pkg::ST_READ) || (d.st == dma_chan_pkg::ST_SINGLE && !ph);
    d.bus_wr   = (d.st == dma_chan_pkg::ST_WRITE) || (d.st == dma_chan_pkg::ST_SINGLE && ph);
    d.bus_own  = d.bus_rd || d.bus_wr;
    d.bus_addr = (d.bus_wr ? d.dst[d.ch] : d.src[d.ch]) + {28'h0, d.beat, 2'h0};
    d.ack_on   = 2'h0;
    d.ack_on[d.ch] = (d.st == dma_chan_pkg::ST_SINGLE)
                   || (d.st == dma_chan_pkg::ST_READ && !ph)
                   || (d.st == dma_chan_pkg::ST_WRITE && ph);
  end

  // Single state register; synchronous reset clears everything
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      q <= '0;
    else
      q <= d;
  end

  assign s_axi_awready = !q.aw_have;
  assign s_axi_wready  = !q.w_have;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign bus_addr      = q.bus_addr;
  assign bus_read      = q.bus_rd;
  assign bus_write     = q.bus_wr;
  assign bus_owned     = q.bus_own;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_unit_done;
    (q.st == dma_chan_pkg::ST_WRITE || q.st == dma_chan_pkg::ST_SINGLE) && done;
  endsequence

  dest_step_inc_a: assert property (s_unit_done and q.ctrl[q.ch][15:14] == 2'h1
    and q.ctrl[q.ch][11:10] == 2'h2 |=> q.dst[$past(q.ch)] == $past(q.dst[q.ch]) + 32'h4)
    else $error("destination did not advance by four");
  dest_step_dec_a: assert property (s_unit_done and q.ctrl[q.ch][15:14] == 2'h2
    and q.ctrl[q.ch][11:10] == 2'h3 |=> q.dst[$past(q.ch)] == $past(q.dst[q.ch]) - 32'h10)
    else $error("destination did not drop by sixteen");
  src_fixed16_a: assert property (s_unit_done and q.ctrl[q.ch][13:12] == 2'h0
    and q.ctrl[q.ch][11:10] == 2'h3 |=> q.src[$past(q.ch)] == $past(q.src[q.ch]) + 32'h10)
    else $error("fixed source in sixteen-byte mode did not advance");
  end_flag_set_a: assert property (s_unit_done and q.count[q.ch] == 24'h1
    |=> q.ctrl[$past(q.ch)][`CTL_END] && q.count[$past(q.ch)] == 24'h0)
    else $error("end flag not set at count zero");
  end_only_zero_a: assert property ($rose(q.ctrl[0][`CTL_END]) |-> q.count[0] == 24'h0)
    else $error("end flag set with count left");
  irq_follows_end_a: assert property (end_irq[0] |=> end_irq[0] || !q.ctrl[0][`CTL_IRQ_EN]
    || $past(q.end_seen[0])) else $error("interrupt dropped without an armed flag clear");
  no_run_disabled_a: assert property (!q.glob_en |=> q.st == dma_chan_pkg::ST_IDLE
    || q.st == dma_chan_pkg::ST_GAP || $past(q.st) == dma_chan_pkg::ST_IDLE)
    else $error("transfer continued without global enable");
  ack_read_phase_a: assert property (q.st == dma_chan_pkg::ST_READ && !q.ctrl[q.ch][`CTL_ACK_PH]
    |-> transfer_acknowledge[q.ch] == q.ctrl[q.ch][`CTL_ACK_POL])
    else $error("acknowledge not active in read cycle");
  steal_gap_a: assert property (s_unit_done and !q.ctrl[q.ch][`CTL_BURST] and q.count[q.ch] != 24'h1
    |=> !bus_owned ##1 1'b1)
    else $error("cycle-steal did not release the bus");
endmodule : dma_channel_control
`default_nettype wire

// File: dma_chan_consts.svh
// Offsets, field positions and counts of the two-channel DMA control block
`ifndef DMA_CHAN_CONSTS_SVH
`define DMA_CHAN_CONSTS_SVH
// Register byte addresses
`define OFS_SRC0   32'hffffff80
`define OFS_DST0   32'hffffff84
`define OFS_CNT0   32'hffffff88
`define OFS_CTL0   32'hffffff8c
`define OFS_SRC1   32'hffffff90
`define OFS_DST1   32'hffffff94
`define OFS_CNT1   32'hffffff98
`define OFS_CTL1   32'hffffff9c
`define OFS_RSEL   32'hffffff70
`define OFS_OPER   32'hffffffb0
// Control word fields
`define CTL_CH_EN   0
`define CTL_END     1
`define CTL_IRQ_EN  2
`define CTL_SINGLE  3
`define CTL_BURST   4
`define CTL_REQ_POL 5
`define CTL_REQ_EDG 6
`define CTL_ACK_POL 7
`define CTL_ACK_PH  8
`define CTL_AUTO    9
`define CTL_SIZE    10
`define CTL_SSTEP   12
`define CTL_DSTEP   14
`define CTL_RESET   16'h0000
// Operation register global enable bit
`define OPER_GEN    0
// Longword beats in a sixteen-byte unit, less one
`define LAST_BEAT16 2'h3
// AXI answers
`define RESP_OK     2'h0
`define RESP_SLVERR 2'h2
`endif

// File: dma_chan_pkg.sv
// Types shared by the DMA channel control block
package dma_chan_pkg;
  typedef enum logic [1:0] {STEP_FIXED, STEP_INC, STEP_DEC, STEP_RSVD} step_t;
  typedef enum logic [1:0] {UNIT_BYTE, UNIT_WORD, UNIT_LONG, UNIT_16} unit_t;
  typedef enum {ST_IDLE, ST_READ, ST_WRITE, ST_SINGLE, ST_GAP} xfer_state_t;
  typedef enum {R_SRC0, R_DST0, R_CNT0, R_CTL0, R_SRC1, R_DST1, R_CNT1, R_CTL1,
                R_RSEL, R_OPER, R_NONE} reg_sel_t;
  typedef struct packed {
    logic                aw_have;
    logic [31:0]         aw_addr;
    logic                w_have;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic [1:0][31:0]    src;
    logic [1:0][31:0]    dst;
    logic [1:0][23:0]    count;
    logic [1:0][15:0]    ctrl;
    logic [1:0]          end_seen;
    logic [1:0][1:0]     rsel;
    logic                glob_en;
    xfer_state_t         st;
    logic                ch;
    logic [1:0]          beat;
    logic [1:0]          ack_on;
    logic [31:0]         bus_addr;
    logic                bus_rd;
    logic                bus_wr;
    logic                bus_own;
  } ctl_state_t;
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic pend;
  } sense_state_t;
endpackage : dma_chan_pkg

// File: dma_addr_step.sv
// Next address after one transfer unit, from the step mode and unit size
`timescale 1ns/1ps
`default_nettype none
module dma_addr_step (
  input  wire logic [31:0] addr_in,
  input  wire logic [1:0]  step,
  input  wire logic [1:0]  size,
  input  wire logic        src_side,
  output logic      [31:0] addr_out
);
  logic [31:0] unit_b;

  // Unit size in bytes; sixteen-byte units move as four longwords
  always_comb
  begin
    unique case (dma_chan_pkg::unit_t'(size))
      dma_chan_pkg::UNIT_BYTE: unit_b = 32'h0000_0001;
      dma_chan_pkg::UNIT_WORD: unit_b = 32'h0000_0002;
      dma_chan_pkg::UNIT_LONG: unit_b = 32'h0000_0004;
      dma_chan_pkg::UNIT_16:   unit_b = 32'h0000_0010;
    endcase
  end

  // Reserved step pattern holds the address rather than guessing
  always_comb
  begin
    unique case (dma_chan_pkg::step_t'(step))
      dma_chan_pkg::STEP_FIXED: addr_out = (src_side && size == 2'h3) ? addr_in + unit_b : addr_in;
      dma_chan_pkg::STEP_INC:   addr_out = addr_in + unit_b;
      dma_chan_pkg::STEP_DEC:   addr_out = addr_in - unit_b;
      dma_chan_pkg::STEP_RSVD:  addr_out = addr_in;
    endcase
  end
endmodule : dma_addr_step
`default_nettype wire

// File: dma_req_sense.sv
// Request pin synchroniser with level or edge sensing and selectable polarity
`timescale 1ns/1ps
`default_nettype none
module dma_req_sense (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic pin,
  input  wire logic edge_mode,
  input  wire logic pol_high,
  input  wire logic take,
  output logic      req
);
  dma_chan_pkg::sense_state_t q;
  dma_chan_pkg::sense_state_t d;
  logic                       hit;

  // Edge seen on the synchronised level; an edge is held until served
  always_comb
  begin
    d       = q;
    d.sync1 = pin;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
    hit     = pol_high ? (q.sync2 & ~q.prev) : (~q.sync2 & q.prev);
    if (take)
      d.pend = 1'b0;
    if (hit && edge_mode)
      d.pend = 1'b1; // New edge wins over a clear
    if (!edge_mode)
      d.pend = 1'b0;
    req = edge_mode ? q.pend : (q.sync2 == pol_high);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      q <= '0;
    else
      q <= d;
  end
endmodule : dma_req_sense
`default_nettype wire

// File: peer_model.sv
// Peripheral model driving the request pins of both channels
`timescale 1ns/1ps
`default_nettype none
module peer_model (
  input  wire logic       sys_clk,
  input  wire logic [1:0] want,
  input  wire logic [1:0] req_high,
  output logic      [1:0] transfer_request_pin
);
  // Active level while wanted, the opposite level when idle
  always @(posedge sys_clk)
  begin
    transfer_request_pin <= want ~^ req_high;
  end
endmodule : peer_model
`default_nettype wire

// File: dma_channel_control_bench.sv
// Self-checking bench for the two-channel DMA control block
`include "dma_chan_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control_bench;
  logic        sys_clk, rst_b, awvalid, wvalid, bready, arvalid, rready, rx_req;
  logic        awready, wready, bvalid, arready, rvalid, own_q, ack_lvl;
  logic [31:0] awaddr, wdata, araddr, rdata, bus_addr, wr_addr;
  logic [1:0]  bresp, rresp, pin, ack, irq, want, req_high;
  logic        bus_read, bus_write, bus_owned;
  int          bad_count, tests_run, cycles, ack_rd, ack_wr, strobes, owns;

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  dma_channel_control DUT (.sys_clk(sys_clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .transfer_request_pin(pin), .rx_full_req(rx_req), .tx_empty_req(1'b0),
    .transfer_acknowledge(ack), .end_irq(irq), .bus_addr(bus_addr),
    .bus_read(bus_read), .bus_write(bus_write), .bus_owned(bus_owned));

  peer_model peer (.sys_clk(sys_clk), .want(want), .req_high(req_high), .transfer_request_pin(pin));

  ////////////////////////////////////////////////////////////////////////
  // Bus activity counters; scenarios compare differences, never reset them
  always @(posedge sys_clk)
  begin
    cycles++;
    strobes += int'(bus_read) + int'(bus_write);
    owns += int'(bus_owned && !own_q);
    ack_rd += int'(ack[0] === ack_lvl && bus_read);
    ack_wr += int'(ack[0] === ack_lvl && bus_write);
    own_q = bus_owned;
    if (bus_write)
      wr_addr = bus_addr;
    if (cycles == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////
  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Program channel 0; a control write with the flag bit 0 also clears an armed flag
  task automatic run(input logic [15:0] ctl, input logic [23:0] n);
    axi_wr(`OFS_SRC0, 32'h00001000);
    axi_wr(`OFS_DST0, 32'h00002000);
    axi_wr(`OFS_CNT0, {8'h00, n});
    axi_wr(`OFS_CTL0, {16'h0000, ctl});
  endtask : run

  // Polling bounded so a stuck channel shows as a flag mismatch
  task automatic wait_end(output logic [31:0] v);
    logic [1:0] r;
    repeat (100)
    begin
      axi_rd(`OFS_CTL0, v, r);
      if (v[`CTL_END])
        break;
    end
  endtask : wait_end

  function automatic int delta(input int mode, input int u);
    return (mode == 1) ? 2 * u : (mode == 2) ? -2 * u : 0;
  endfunction : delta

  ////////////////////////////////////////////////////////////////////////
  task automatic reset_check;
    logic [31:0] v;
    logic [1:0]  r;
    axi_rd(`OFS_CTL1, v, r);
    check("control reset", 32'h0, v);
    check("ack idle", 32'h3, {30'h0, ack});
    axi_rd(32'hffffff00, v, r);
    check("unmapped resp", 32'h2, {30'h0, r});
    axi_wr(32'hffffff00, 32'h0);
    check("unmapped write resp", 32'h2, {30'h0, bresp});
  endtask : reset_check

  // Every non-reserved step pair over every unit size, two units each
  task automatic step_table;
    logic [31:0] v;
    logic [1:0]  r;
    int          u;
    axi_wr(`OFS_OPER, 32'h1);
    for (int sz = 0; sz < 4; sz++)
      for (int st = 0; st < 9; st++)
      begin
        u = (sz == 3) ? 16 : 1 << sz;
        run(16'(((st % 3) << 14) | ((st / 3) << 12) | (sz << 10) | 16'h0201), 24'h2);
        wait_end(v);
        axi_rd(`OFS_DST0, v, r);
        check("dest", 32'h2000 + 32'(delta(st % 3, u)), v);
        axi_rd(`OFS_SRC0, v, r);
        check("source", 32'h1000 + 32'(delta(st / 3, u) + ((st < 3 && sz == 3) ? 32 : 0)), v);
      end
  endtask : step_table

  task automatic gate_check;
    logic [31:0] v;
    logic [1:0]  r;
    run(16'h0200, 24'h3);
    axi_wr(`OFS_CNT0, 32'hff000003);
    repeat (20) @(posedge sys_clk);
    axi_rd(`OFS_CNT0, v, r);
    check("count idle", 32'h3, v);
    axi_wr(`OFS_OPER, 32'h0);
    axi_wr(`OFS_CTL0, 32'h0201);
    repeat (20) @(posedge sys_clk);
    axi_rd(`OFS_CTL0, v, r);
    check("flag idle", 32'h0, {31'h0, v[`CTL_END]});
    axi_wr(`OFS_OPER, 32'h1);
    wait_end(v);
    check("flag end", 32'h1, {31'h0, v[`CTL_END]});
    check("irq off", 32'h0, {30'h0, irq});
    axi_rd(`OFS_CNT0, v, r);
    check("count end", 32'h0, v);
    // Writing 1 leaves the flag; a zero write without a prior read is ignored
    axi_wr(`OFS_CTL0, 32'h0006);
    check("irq on", 32'h1, {30'h0, irq});
    axi_wr(`OFS_CTL0, 32'h0004);
    check("irq kept", 32'h1, {30'h0, irq});
    axi_rd(`OFS_CTL0, v, r);
    axi_wr(`OFS_CTL0, 32'h0004);
    check("irq cleared", 32'h0, {30'h0, irq});
  endtask : gate_check

  // Ack phase, ack and request polarity, level and edge sensing
  task automatic pin_table;
    logic [31:0] v;
    logic [1:0]  r;
    int          a0, a1;
    for (int m = 0; m < 8; m++)
    begin
      axi_wr(`OFS_CTL0, 32'h0); // Level mode drops an edge left from the last polarity
      req_high <= {2{m[1]}};
      ack_lvl = m[1];
      run(16'((m[0] << 8) | (m[1] << 7) | (m[2] << 6) | (m[1] << 5) | 1), 24'h1);
      repeat (10) @(posedge sys_clk);
      axi_rd(`OFS_CNT0, v, r);
      check("count no request", 32'h1, v);
      a0 = ack_rd;
      a1 = ack_wr;
      want <= 2'h1;
      wait_end(v);
      want <= 2'h0;
      check("ack in read", 32'(m[0] ? 0 : 1), 32'(ack_rd - a0));
      check("ack in write", 32'(m[0]), 32'(ack_wr - a1));
    end
  endtask : pin_table

  // Cycle-steal, burst and single addressing, three byte units each
  task automatic mode_table;
    logic [31:0] v;
    int          s, o;
    for (int m = 0; m < 3; m++)
    begin
      s = strobes;
      o = owns;
      run(16'h0201 | (m == 1 ? 16'h0010 : 16'h0) | (m == 2 ? 16'h0008 : 16'h0), 24'h3);
      wait_end(v);
      check("bus strobes", 32'(m == 2 ? 3 : 6), 32'(strobes - s));
      check("bus grants", 32'(m == 1 ? 1 : 3), 32'(owns - o));
      check("write address", 32'h2000, wr_addr);
    end
  endtask : mode_table

  // Receive-full request starts channel 0; the prohibited code never requests
  task automatic source_check;
    logic [31:0] v;
    logic [1:0]  r;
    axi_wr(`OFS_RSEL, 32'h1);
    rx_req <= 1'b1;
    run(16'h0001, 24'h1);
    wait_end(v);
    check("rx request", 32'h1, {31'h0, v[`CTL_END]});
    axi_wr(`OFS_RSEL, 32'h3);
    run(16'h0001, 24'h1);
    repeat (20) @(posedge sys_clk);
    axi_rd(`OFS_CNT0, v, r);
    check("no request", 32'h1, v);
  endtask : source_check

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, own_q, ack_lvl, rx_req} = 9'h000;
    {awaddr, wdata, araddr} = 96'h0;
    want = 2'h0;
    req_high = 2'h0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    reset_check();
    step_table();
    gate_check();
    pin_table();
    mode_table();
    source_check();
    report_and_stop();
  end
endmodule : dma_channel_control_bench
`default_nettype wire
